// file: logic/sfc_pkg.sv
// shared constants, offsets and carrier types of the synthesizer config block
package sfc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int SFC_ADDR_W = 12;
  localparam int SFC_DATA_W = 32;

  // register byte offsets
  localparam logic [11:0] SFC_OFS_PUMP_PRESCALER_MUX = 12'h000;
  localparam logic [11:0] SFC_OFS_FRACTION_UPPER = 12'h004;
  localparam logic [11:0] SFC_OFS_FRAC_CONFIG = 12'h008;
  localparam logic [11:0] SFC_OFS_NUMERATOR_STATUS = 12'h00C;
  localparam logic [11:0] SFC_OFS_DENOMINATOR_STATUS = 12'h010;
  localparam logic [11:0] SFC_OFS_PIN_STATUS = 12'h014;
  localparam logic [11:0] SFC_OFS_COUNT_STATUS = 12'h018;

  ////////////////////////////////////////////////////////////////////////////
  // pump_prescaler_mux_word fields
  localparam int SFC_POS_PUMP_POLARITY = 9;
  localparam int SFC_POS_IF_PRESCALER = 8;
  localparam int SFC_POS_SELECT_LO = 4;
  localparam int SFC_SELECT_W = 4;
  // fraction_upper_word fields
  localparam int SFC_POS_NUM_UPPER_LO = 4;
  localparam int SFC_POS_DEN_UPPER_LO = 14;
  localparam int SFC_UPPER_W = 10;
  // frac config word fields
  localparam int SFC_POS_NUM_LOWER_LO = 0;
  localparam int SFC_POS_DEN_LOWER_LO = 12;
  localparam int SFC_POS_WIDE_FRACTION = 24;
  localparam int SFC_POS_REF_DOUBLER = 25;
  localparam int SFC_LOWER_W = 12;
  localparam int SFC_FRAC_W = 22;
  localparam int SFC_WORD_W = 24;
  localparam int SFC_CFG_W = 26;

  ////////////////////////////////////////////////////////////////////////////
  // reset values: positive pump polarity, pin in high impedance
  localparam logic [23:0] SFC_RST_PUMP_PRESCALER_MUX = 24'h00_0200;
  localparam logic [23:0] SFC_RST_FRACTION_UPPER = 24'h00_0000;
  localparam logic [25:0] SFC_RST_FRAC_CONFIG = 26'h000_0000;
  localparam logic [31:0] SFC_RST_RDATA = 32'h0000_0000;
  localparam logic [3:0] SFC_STRB_FULL = 4'hF;
  localparam logic [1:0] SFC_REF_RATE_SINGLE = 2'h1;
  localparam logic [1:0] SFC_REF_RATE_DOUBLE = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // test/lock pin selector codes
  typedef enum logic [3:0] {
    SFC_SEL_HIGH_Z, SFC_SEL_DRIVE_HIGH, SFC_SEL_DRIVE_LOW, SFC_SEL_DIG_BOTH,
    SFC_SEL_DIG_RF, SFC_SEL_DIG_IF, SFC_SEL_OD_ANA_BOTH, SFC_SEL_OD_ANA_RF,
    SFC_SEL_OD_ANA_IF, SFC_SEL_PP_ANA_BOTH, SFC_SEL_PP_ANA_RF, SFC_SEL_PP_ANA_IF,
    SFC_SEL_IF_REF_DIV, SFC_SEL_IF_FB_DIV, SFC_SEL_RF_REF_DIV, SFC_SEL_RF_FB_DIV
  } sfc_select_type;

  // lock detect levels, all four together
  typedef struct packed {
    logic rf_dig;
    logic if_dig;
    logic rf_ana;
    logic if_ana;
  } sfc_lock_type;

  // pin as output value and output enable
  typedef struct packed {
    logic o;
    logic oe;
  } sfc_pin_type;

  // effective fraction
  typedef struct packed {
    logic [21:0] num;
    logic [21:0] den;
  } sfc_frac_type;

endpackage : sfc_pkg

// file: logic/sfc_frac_assemble.sv
// assembles effective fractional numerator and denominator from the mode bit
`timescale 1ns/1ps
module sfc_frac_assemble
  import sfc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wide,
  input wire logic [9:0] i_num_upper,
  input wire logic [11:0] i_num_lower,
  input wire logic [9:0] i_den_upper,
  input wire logic [11:0] i_den_lower,
  output sfc_frac_type o_frac
);

  sfc_frac_type state_q;
  sfc_frac_type state_d;

  ////////////////////////////////////////////////////////////////////////////
  // narrow mode zeroes the upper bits instead of trusting what was written
  always_comb begin
    state_d = state_q;
    if (i_wide) begin
      state_d.num = {i_num_upper, i_num_lower};
      state_d.den = {i_den_upper, i_den_lower};
    end else begin
      state_d.num = {10'h000, i_num_lower};
      state_d.den = {10'h000, i_den_lower};
    end
  end

  // one register stage so the counters see a clean word
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_frac = state_q;

endmodule : sfc_frac_assemble

// file: logic/sfc_test_lock_mux.sv
// drives the test/lock pin from the selector, lock levels and divider pulses
`timescale 1ns/1ps
module sfc_test_lock_mux
  import sfc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_select,
  input sfc_lock_type i_lock,
  input wire logic [3:0] i_div_pulse,
  output sfc_pin_type o_pin
);

  typedef struct packed {
    logic [3:0] half;
    sfc_pin_type pin;
  } sfc_mux_state_type;

  sfc_mux_state_type state_q;
  sfc_mux_state_type state_d;

  ////////////////////////////////////////////////////////////////////////////
  // halvers run always, so a selector change shows an already settled wave
  always_comb begin
    state_d = state_q;
    for (int i = 0; i < 4; i++) begin
      if (i_div_pulse[i]) begin
        state_d.half[i] = ~state_q.half[i];
      end
    end
    state_d.pin.oe = 1'b1;
    state_d.pin.o = 1'b0;
    case (sfc_select_type'(i_select))
      SFC_SEL_HIGH_Z: begin
        state_d.pin.oe = 1'b0;
      end
      SFC_SEL_DRIVE_HIGH: state_d.pin.o = 1'b1;
      SFC_SEL_DRIVE_LOW: state_d.pin.o = 1'b0;
      SFC_SEL_DIG_BOTH: state_d.pin.o = i_lock.rf_dig & i_lock.if_dig;
      SFC_SEL_DIG_RF: state_d.pin.o = i_lock.rf_dig;
      SFC_SEL_DIG_IF: state_d.pin.o = i_lock.if_dig;
      // open drain only pulls low; a high level floats to the pull-up
      SFC_SEL_OD_ANA_BOTH: begin
        state_d.pin.oe = ~(i_lock.rf_ana & i_lock.if_ana);
      end
      SFC_SEL_OD_ANA_RF: state_d.pin.oe = ~i_lock.rf_ana;
      SFC_SEL_OD_ANA_IF: state_d.pin.oe = ~i_lock.if_ana;
      SFC_SEL_PP_ANA_BOTH: state_d.pin.o = i_lock.rf_ana & i_lock.if_ana;
      SFC_SEL_PP_ANA_RF: state_d.pin.o = i_lock.rf_ana;
      SFC_SEL_PP_ANA_IF: state_d.pin.o = i_lock.if_ana;
      SFC_SEL_IF_REF_DIV: state_d.pin.o = state_q.half[0];
      SFC_SEL_IF_FB_DIV: state_d.pin.o = state_q.half[1];
      SFC_SEL_RF_REF_DIV: state_d.pin.o = state_q.half[2];
      default: state_d.pin.o = state_q.half[3];
    endcase
  end

  // pin value and enable leave from flops, no glitches on the pad
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_pin = state_q.pin;

endmodule : sfc_test_lock_mux

// file: logic/sfc_config_top.sv
// apb register bank for pump polarity, prescaler, test/lock pin and fraction
//
// Notes on behaviour
// - bit 9 sets pump polarity, positive default
// - bit 8 picks 8/9 or 16/17 prescaler
// - selector bits 7:4; code zero floats pin
// - codes 1-5: high, low, digital locks push-pull
// - codes 6-11: analog locks, open-drain then push-pull
// - codes 12-15: halved divider outputs, push-pull
// - doubler doubles rf reference rate only
// - narrow mode ignores upper numerator bits
// - wide mode stacks upper numerator above lower
// - denominator follows numerator mode handling
//
// register map, byte offsets
// 0x00 mux word, write only
//   9 pump polarity, 1 positive
//   8 prescaler, 1 picks 16/17
//   7:4 test/lock pin selector
// 0x04 upper word, write only
//   23:14 denominator upper ten
//   13:4 numerator upper ten
// 0x08 config word, write only
//   11:0 numerator lower twelve
//   23:12 denominator lower twelve
//   24 wide fraction mode
//   25 rf reference doubler
// 0x0C effective numerator
// 0x10 effective denominator
// 0x14 pin and synced locks
//   0 pin value, 1 pin enable
//   5:2 rf_dig, if_dig, rf_ana, if_ana
// 0x18 access counters, wrapping
//   15:0 accepted writes, 31:16 refused
// write-only words read as zero
//
// latency from the access edge
//   at that edge: polarity, prescaler, rate
//   one edge later: fraction and pin
//   lock input to pin: three edges
//
// hazards
//   a partial strobe is refused whole
//   status reads snapshot at setup
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module sfc_config_top
  import sfc_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  output logic O_PREADY,
  output logic [31:0] O_PRDATA,
  output logic O_PSLVERR,
  // lock detect levels from the loops, asynchronous
  input wire logic I_RF_DIG_LOCK,
  input wire logic I_IF_DIG_LOCK,
  input wire logic I_RF_ANA_LOCK,
  input wire logic I_IF_ANA_LOCK,
  // divider terminal-count pulses, on the system clock
  input wire logic I_IF_REF_DIV_PULSE,
  input wire logic I_IF_FB_DIV_PULSE,
  input wire logic I_RF_REF_DIV_PULSE,
  input wire logic I_RF_FB_DIV_PULSE,
  // configuration towards the loops
  output logic O_RF_PUMP_POSITIVE,
  output logic O_IF_PRESCALER_16_17,
  output logic [1:0] O_RF_REF_RATE,
  output logic [1:0] O_IF_REF_RATE,
  output logic O_WIDE_FRACTION,
  output logic [21:0] O_FRAC_NUMERATOR,
  output logic [21:0] O_FRAC_DENOMINATOR,
  // test/lock pin
  output logic O_TEST_LOCK_PIN_O,
  output logic O_TEST_LOCK_PIN_OE
);

  ////////////////////////////////////////////////////////////////////////////
  // whole state of the bank
  typedef struct packed {
    logic [23:0] mux_word;
    logic [23:0] upper_word;
    logic [25:0] cfg_word;
    logic [31:0] rdata;
    sfc_lock_type lock_meta;
    sfc_lock_type lock_sync;
    logic [15:0] write_count;
    logic [15:0] reject_count;
  } sfc_top_state_type;

  sfc_top_state_type state_q;
  sfc_top_state_type state_d;

  // bus phase
  logic setup_phase;
  logic access_phase;

  // decoded register selects
  logic hit_mux;
  logic hit_upper;
  logic hit_cfg;
  logic hit_num_stat;
  logic hit_den_stat;
  logic hit_pin_stat;
  logic hit_cnt_stat;

  // write qualification
  logic hit_writable;
  logic hit_any;
  logic full_strobe;
  logic write_ok;
  logic write_bad;

  // links to the sub-blocks
  logic [3:0] div_pulse;
  sfc_frac_type frac;
  sfc_pin_type pin;

  // fields of the held words
  logic [3:0] select_field;
  logic [9:0] num_upper_field;
  logic [9:0] den_upper_field;
  logic [11:0] num_lower_field;
  logic [11:0] den_lower_field;
  logic wide_mode;
  logic doubler_on;

  ////////////////////////////////////////////////////////////////////////////
  // apb phase and address decode
  assign setup_phase = I_PSEL & ~I_PENABLE;
  assign access_phase = I_PSEL & I_PENABLE;

  // full byte addresses, so a misaligned address is simply unmapped
  always_comb begin
    hit_mux = 1'b0;
    hit_upper = 1'b0;
    hit_cfg = 1'b0;
    hit_num_stat = 1'b0;
    hit_den_stat = 1'b0;
    hit_pin_stat = 1'b0;
    hit_cnt_stat = 1'b0;
    // at most one select is raised
    if (I_PADDR == SFC_OFS_PUMP_PRESCALER_MUX) begin
      hit_mux = 1'b1;
    end else if (I_PADDR == SFC_OFS_FRACTION_UPPER) begin
      hit_upper = 1'b1;
    end else if (I_PADDR == SFC_OFS_FRAC_CONFIG) begin
      hit_cfg = 1'b1;
    end else if (I_PADDR == SFC_OFS_NUMERATOR_STATUS) begin
      hit_num_stat = 1'b1;
    end else if (I_PADDR == SFC_OFS_DENOMINATOR_STATUS) begin
      hit_den_stat = 1'b1;
    end else if (I_PADDR == SFC_OFS_PIN_STATUS) begin
      hit_pin_stat = 1'b1;
    end else if (I_PADDR == SFC_OFS_COUNT_STATUS) begin
      hit_cnt_stat = 1'b1;
    end
  end

  assign hit_writable = hit_mux | hit_upper | hit_cfg;
  assign hit_any = hit_writable | hit_num_stat | hit_den_stat | hit_pin_stat | hit_cnt_stat;
  assign full_strobe = (I_PSTRB == SFC_STRB_FULL);

  // a partial strobe would leave a half-updated field, so it is refused
  assign write_ok = access_phase & I_PWRITE & hit_writable & full_strobe;
  assign write_bad = access_phase & I_PWRITE & ~(hit_writable & full_strobe);

  // zero wait states; errors for unmapped, read-only or partial writes
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = access_phase & (~hit_any | write_bad);

  ////////////////////////////////////////////////////////////////////////////
  // next state: register writes, read snapshot, lock synchronisers
  always_comb begin
    state_d = state_q;
    // first stage feeds only the second stage
    state_d.lock_meta = '{rf_dig: I_RF_DIG_LOCK, if_dig: I_IF_DIG_LOCK,
                          rf_ana: I_RF_ANA_LOCK, if_ana: I_IF_ANA_LOCK};
    state_d.lock_sync = state_q.lock_meta;

    // whole word lands at the access edge, never field by field
    if (write_ok) begin
      if (hit_mux) begin
        state_d.mux_word = I_PWDATA[SFC_WORD_W-1:0];
      end else if (hit_upper) begin
        state_d.upper_word = I_PWDATA[SFC_WORD_W-1:0];
      end else begin
        state_d.cfg_word = I_PWDATA[SFC_CFG_W-1:0];
      end
      // counters are a status aid only, they wrap
      state_d.write_count = state_q.write_count + 16'h0001;
    end else if (write_bad | (access_phase & ~hit_any)) begin
      // unmapped reads count as refused too
      state_d.reject_count = state_q.reject_count + 16'h0001;
    end

    // read data is captured in setup and held through the access phase
    if (setup_phase) begin
      // write-only and unmapped words read as zero
      state_d.rdata = SFC_RST_RDATA;
      if (~I_PWRITE) begin
        // status words are zero-extended to the bus
        if (hit_num_stat) begin
          state_d.rdata = {10'h000, frac.num};
        end else if (hit_den_stat) begin
          state_d.rdata = {10'h000, frac.den};
        end else if (hit_pin_stat) begin
          state_d.rdata = {26'h000_0000, state_q.lock_sync, pin.oe, pin.o};
        end else if (hit_cnt_stat) begin
          state_d.rdata = {state_q.reject_count, state_q.write_count};
        end
      end
    end
  end

  // one clocked process for the whole bank
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      state_q.mux_word <= SFC_RST_PUMP_PRESCALER_MUX;
      state_q.upper_word <= SFC_RST_FRACTION_UPPER;
      state_q.cfg_word <= SFC_RST_FRAC_CONFIG;
      state_q.rdata <= SFC_RST_RDATA;
      // syncs restart low: locks read as unlocked
      state_q.lock_meta <= '0;
      state_q.lock_sync <= '0;
      state_q.write_count <= 16'h0000;
      state_q.reject_count <= 16'h0000;
    end else begin
      state_q <= state_d;
    end
  end

  assign O_PRDATA = state_q.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // fields of the held words, named once for every user
  assign select_field = state_q.mux_word[SFC_POS_SELECT_LO +: SFC_SELECT_W];
  assign num_upper_field = state_q.upper_word[SFC_POS_NUM_UPPER_LO +: SFC_UPPER_W];
  assign den_upper_field = state_q.upper_word[SFC_POS_DEN_UPPER_LO +: SFC_UPPER_W];
  assign num_lower_field = state_q.cfg_word[SFC_POS_NUM_LOWER_LO +: SFC_LOWER_W];
  assign den_lower_field = state_q.cfg_word[SFC_POS_DEN_LOWER_LO +: SFC_LOWER_W];
  assign wide_mode = state_q.cfg_word[SFC_POS_WIDE_FRACTION];
  assign doubler_on = state_q.cfg_word[SFC_POS_REF_DOUBLER];

  ////////////////////////////////////////////////////////////////////////////
  // loop configuration outputs, straight from the held words
  assign O_RF_PUMP_POSITIVE = state_q.mux_word[SFC_POS_PUMP_POLARITY];
  assign O_IF_PRESCALER_16_17 = state_q.mux_word[SFC_POS_IF_PRESCALER];

  // mode bit leaves with no extra stage
  assign O_WIDE_FRACTION = wide_mode;

  // rate is a count step per reference edge; if side never doubles
  assign O_RF_REF_RATE = doubler_on ?
                         SFC_REF_RATE_DOUBLE : SFC_REF_RATE_SINGLE;
  assign O_IF_REF_RATE = SFC_REF_RATE_SINGLE;

  ////////////////////////////////////////////////////////////////////////////
  // fraction assembly
  // narrow mode is settled inside the assembler
  sfc_frac_assemble u_frac (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_wide(wide_mode),
    .i_num_upper(num_upper_field),
    .i_num_lower(num_lower_field),
    .i_den_upper(den_upper_field),
    .i_den_lower(den_lower_field),
    .o_frac(frac)
  );

  // fraction outputs carry the assembly stage
  assign O_FRAC_NUMERATOR = frac.num;
  assign O_FRAC_DENOMINATOR = frac.den;

  ////////////////////////////////////////////////////////////////////////////
  // test/lock pin
  assign div_pulse = {I_RF_FB_DIV_PULSE, I_RF_REF_DIV_PULSE,
                      I_IF_FB_DIV_PULSE, I_IF_REF_DIV_PULSE};

  // lock levels reach the mux already synchronised
  sfc_test_lock_mux u_mux (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_select(select_field),
    .i_lock(state_q.lock_sync),
    .i_div_pulse(div_pulse),
    .o_pin(pin)
  );

  // enable high means the pad drives
  assign O_TEST_LOCK_PIN_O = pin.o;
  assign O_TEST_LOCK_PIN_OE = pin.oe;

endmodule : sfc_config_top

// file: verif/sfc_config_properties.sv
// concurrent checks on the ports of the synthesizer config block
`timescale 1ns/1ps
module sfc_config_properties
  import sfc_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  input wire logic O_RF_PUMP_POSITIVE,
  input wire logic O_IF_PRESCALER_16_17,
  input wire logic [1:0] O_RF_REF_RATE,
  input wire logic [1:0] O_IF_REF_RATE,
  input wire logic O_WIDE_FRACTION,
  input wire logic [21:0] O_FRAC_NUMERATOR,
  input wire logic [21:0] O_FRAC_DENOMINATOR,
  input wire logic O_TEST_LOCK_PIN_O,
  input wire logic O_TEST_LOCK_PIN_OE
);
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (I_RST);
  ////////////////////////////////////////////////////////////////
  // full-strobe writes taken at this edge, per target word
  logic wr_ok;
  logic wr_mux;
  logic wr_up;
  logic wr_cfg;
  logic [3:0] sel;
  assign wr_ok = I_PSEL && I_PENABLE && I_PWRITE && (I_PSTRB == SFC_STRB_FULL);
  assign wr_mux = wr_ok && (I_PADDR == SFC_OFS_PUMP_PRESCALER_MUX);
  assign wr_up = wr_ok && (I_PADDR == SFC_OFS_FRACTION_UPPER);
  assign wr_cfg = wr_ok && (I_PADDR == SFC_OFS_FRAC_CONFIG);
  assign sel = I_PWDATA[7:4];
  ////////////////////////////////////////////////////////////////
  a_pump_polarity: assert property (wr_mux |=> O_RF_PUMP_POSITIVE == $past(I_PWDATA[9]))
    else $error("pump polarity does not follow bit 9");
  a_prescaler_pick: assert property (wr_mux |=> O_IF_PRESCALER_16_17 == $past(I_PWDATA[8]))
    else $error("prescaler does not follow bit 8");
  a_pin_float: assert property (wr_mux && sel == 4'h0 |=> ##1 !O_TEST_LOCK_PIN_OE)
    else $error("pin driven with selector zero");
  a_pin_const: assert property (wr_mux && sel inside {4'h1, 4'h2} |=> ##1
    O_TEST_LOCK_PIN_OE && (O_TEST_LOCK_PIN_O == $past(I_PWDATA[4], 2)))
    else $error("constant pin level wrong");
  a_open_drain: assert property (wr_mux && sel inside {[4'h6:4'h8]} |=> ##1 !O_TEST_LOCK_PIN_O)
    else $error("open-drain pin drives high");
  a_push_pull: assert property (wr_mux && sel inside {[4'h1:4'h5], [4'h9:4'hF]}
    |=> ##1 O_TEST_LOCK_PIN_OE)
    else $error("push-pull pin not driven");
  a_rf_doubler: assert property (wr_cfg |=> (O_IF_REF_RATE == SFC_REF_RATE_SINGLE) &&
    (O_RF_REF_RATE == ($past(I_PWDATA[25]) ? SFC_REF_RATE_DOUBLE : SFC_REF_RATE_SINGLE)))
    else $error("reference rate wrong");
  a_narrow_frac: assert property (wr_cfg && !I_PWDATA[24] |=> ##1
    O_FRAC_NUMERATOR == {10'h000, $past(I_PWDATA[11:0], 2)} &&
    O_FRAC_DENOMINATOR == {10'h000, $past(I_PWDATA[23:12], 2)})
    else $error("narrow fraction not zero-extended");
  a_wide_frac: assert property (wr_up && O_WIDE_FRACTION |=> ##1
    O_FRAC_NUMERATOR[21:12] == $past(I_PWDATA[13:4], 2) &&
    O_FRAC_DENOMINATOR[21:12] == $past(I_PWDATA[23:14], 2))
    else $error("wide fraction upper bits wrong");
  a_hold_no_write: assert property (!(wr_mux || wr_cfg) |=> $stable(O_RF_PUMP_POSITIVE) &&
    $stable(O_IF_PRESCALER_16_17) && $stable(O_WIDE_FRACTION) && $stable(O_RF_REF_RATE))
    else $error("setting changed without a complete write");
endmodule : sfc_config_properties

// file: verif/sfc_host_model.sv
// apb master standing in for the host controller
`timescale 1ns/1ps
module sfc_host_model (
  input wire logic i_clk,
  input wire logic i_pready,
  input wire logic [31:0] i_prdata,
  input wire logic i_pslverr,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [11:0] o_paddr,
  output logic [31:0] o_pwdata,
  output logic [3:0] o_pstrb
);
  // idle bus at time zero
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 12'h000;
    o_pwdata = 32'h0000_0000;
    o_pstrb = 4'h0;
  end
  // one transfer: setup, then access held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] r, output logic e);
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    o_pstrb <= s;
    @(posedge i_clk);
    o_penable <= 1'b1;
    // no wait-state count assumed; only the bench watchdog ends a hang
    do begin
      @(posedge i_clk);
    end while (i_pready !== 1'b1);
    r = i_prdata;
    e = i_pslverr;
    // released address and data flip so nothing rides on a stale value
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    o_paddr <= ~a;
    o_pwdata <= ~d;
  endtask : xfer
endmodule : sfc_host_model

// file: verif/tb_synth_frac_config_and_test_mux.sv
// self-checking bench for the synthesizer config block
`timescale 1ns/1ps
module tb_synth_frac_config_and_test_mux;
  import sfc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] lk = 4'h0;
  logic [3:0] dv = 4'h0;
  logic psel, pen, pwr, rdy, slverr, pump, pre, wide, po, poe, o0;
  logic [11:0] addr;
  logic [31:0] wdat, rdat;
  logic [3:0] strb;
  logic [1:0] rrate, irate;
  logic [21:0] num, den;
  logic [1:0] pe;
  int n_fail = 0;
  int checks = 0;
  localparam logic [11:0] MUX = SFC_OFS_PUMP_PRESCALER_MUX;
  localparam logic [11:0] CFG = SFC_OFS_FRAC_CONFIG;
  ////////////////////////////////////////////////////////////////
  // clock and reset
  initial begin
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
  end
  sfc_host_model host (.i_clk(clk), .i_pready(rdy), .i_prdata(rdat), .i_pslverr(slverr),
    .o_psel(psel), .o_penable(pen), .o_pwrite(pwr), .o_paddr(addr), .o_pwdata(wdat),
    .o_pstrb(strb));
  sfc_config_top uut (.I_SYS_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(addr), .I_PWDATA(wdat), .I_PSTRB(strb), .O_PREADY(rdy),
    .O_PRDATA(rdat), .O_PSLVERR(slverr), .I_RF_DIG_LOCK(lk[3]), .I_IF_DIG_LOCK(lk[2]),
    .I_RF_ANA_LOCK(lk[1]), .I_IF_ANA_LOCK(lk[0]), .I_IF_REF_DIV_PULSE(dv[3]),
    .I_IF_FB_DIV_PULSE(dv[2]), .I_RF_REF_DIV_PULSE(dv[1]), .I_RF_FB_DIV_PULSE(dv[0]),
    .O_RF_PUMP_POSITIVE(pump), .O_IF_PRESCALER_16_17(pre), .O_RF_REF_RATE(rrate),
    .O_IF_REF_RATE(irate), .O_WIDE_FRACTION(wide), .O_FRAC_NUMERATOR(num),
    .O_FRAC_DENOMINATOR(den), .O_TEST_LOCK_PIN_O(po), .O_TEST_LOCK_PIN_OE(poe));
  ////////////////////////////////////////////////////////////////
  // compare, bus wrappers, pin expectation
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (exp !== got) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic e);
    logic [31:0] r;
    logic x;
    host.xfer(1'b1, a, d, s, r, x);
    chk("write error", e, x);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic e);
    logic [31:0] r;
    logic x;
    host.xfer(1'b0, a, 32'h0000_0000, 4'h0, r, x);
    chk("read error", e, x);
    chk("read data", d, r);
  endtask : rd
  // enough edges for the pin stage; checks read values settled before the edge
  task automatic settle;
    repeat (4) @(posedge clk);
  endtask : settle
  function automatic logic [1:0] pin_exp(input int c, input logic r, input logic f);
    case (c)
      0: return 2'b00;
      1: return 2'b11;
      2: return 2'b01;
      3, 9: return {r & f, 1'b1};
      4, 10: return {r, 1'b1};
      5, 11: return {f, 1'b1};
      6: return {1'b0, ~(r & f)};
      7: return {1'b0, ~r};
      default: return {1'b0, ~f};
    endcase
  endfunction : pin_exp
  task report_and_stop;
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    n_fail++;
    report_and_stop;
  end
  // main sequence
  initial begin
    wait (rst == 1'b0);
    @(posedge clk);
    chk("pump", 1, pump);
    chk("pin oe", 0, poe);
    chk("rf rate", SFC_REF_RATE_SINGLE, rrate);
    $display("test reset done");
    wr(MUX, 32'h0000_0100, SFC_STRB_FULL, 0);
    settle;
    chk("pump", 0, pump);
    chk("prescaler", 1, pre);
    wr(MUX, 32'h0000_0200, SFC_STRB_FULL, 0);
    settle;
    chk("pump", 1, pump);
    chk("prescaler", 0, pre);
    $display("test polarity done");
    // every lock code, first all locked, then rf unlocked
    for (int p = 0; p < 2; p++) begin
      lk <= p ? 4'b0101 : 4'b1111;
      for (int c = 0; c < 12; c++) begin
        wr(MUX, 32'h0000_0200 | (c << 4), SFC_STRB_FULL, 0);
        settle;
        pe = pin_exp(c, !p, 1'b1);
        chk("pin", pe, {po, poe});
        rd(SFC_OFS_PIN_STATUS, {lk, pe[0], pe[1]}, 0);
      end
    end
    $display("test lock mux done");
    // halved dividers: own pulse flips the pin, a neighbour's does not
    for (int k = 0; k < 4; k++) begin
      wr(MUX, 32'h0000_0200 | ((12 + k) << 4), SFC_STRB_FULL, 0);
      settle;
      o0 = po;
      dv <= 4'b1000 >> k;
      @(posedge clk);
      dv <= 4'h0;
      settle;
      chk("divider pin", {~o0, 1'b1}, {po, poe});
      dv <= 4'b1000 >> ((k + 1) % 4);
      @(posedge clk);
      dv <= 4'h0;
      settle;
      chk("divider pin", {~o0, 1'b1}, {po, poe});
    end
    $display("test divider done");
    wr(SFC_OFS_FRACTION_UPPER, (32'h155 << 14) | (32'h2AB << 4), SFC_STRB_FULL, 0);
    wr(CFG, (32'h1 << 25) | (32'h123 << 12) | 32'hABC, SFC_STRB_FULL, 0);
    settle;
    chk("numerator", {10'h000, 12'hABC}, num);
    chk("denominator", {10'h000, 12'h123}, den);
    chk("rf rate", SFC_REF_RATE_DOUBLE, rrate);
    chk("if rate", SFC_REF_RATE_SINGLE, irate);
    chk("wide", 0, wide);
    wr(CFG, (32'h3 << 24) | (32'h123 << 12) | 32'hABC, SFC_STRB_FULL, 0);
    settle;
    chk("numerator", {10'h2AB, 12'hABC}, num);
    chk("denominator", {10'h155, 12'h123}, den);
    chk("wide", 1, wide);
    rd(SFC_OFS_NUMERATOR_STATUS, {10'h2AB, 12'hABC}, 0);
    rd(SFC_OFS_DENOMINATOR_STATUS, {10'h155, 12'h123}, 0);
    wr(SFC_OFS_FRACTION_UPPER, 32'h00FF_FFF0, SFC_STRB_FULL, 0);
    wr(CFG, 32'h0100_0FFF, SFC_STRB_FULL, 0);
    settle;
    chk("numerator", 22'd4194303, num);
    chk("rf rate", SFC_REF_RATE_SINGLE, rrate);
    wr(SFC_OFS_FRACTION_UPPER, 32'h0000_0000, SFC_STRB_FULL, 0);
    settle;
    chk("numerator", 22'd4095, num);
    $display("test fraction done");
    // refused accesses leave every setting alone
    wr(MUX, 32'h0000_0100, 4'h7, 1);
    wr(SFC_OFS_NUMERATOR_STATUS, 32'h0000_0000, SFC_STRB_FULL, 1);
    settle;
    chk("pump", 1, pump);
    chk("prescaler", 0, pre);
    rd(12'h100, 32'h0000_0000, 1);
    rd(MUX, 32'h0000_0000, 0);
    rd(SFC_OFS_COUNT_STATUS, 32'h0003_0024, 0);
    $display("test refusal done");
    report_and_stop;
  end
endmodule : tb_synth_frac_config_and_test_mux

bind sfc_config_top sfc_config_properties u_props (.I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST),
  .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
  .I_PWDATA(I_PWDATA), .I_PSTRB(I_PSTRB), .O_RF_PUMP_POSITIVE(O_RF_PUMP_POSITIVE),
  .O_IF_PRESCALER_16_17(O_IF_PRESCALER_16_17), .O_RF_REF_RATE(O_RF_REF_RATE),
  .O_IF_REF_RATE(O_IF_REF_RATE), .O_WIDE_FRACTION(O_WIDE_FRACTION),
  .O_FRAC_NUMERATOR(O_FRAC_NUMERATOR), .O_FRAC_DENOMINATOR(O_FRAC_DENOMINATOR),
  .O_TEST_LOCK_PIN_O(O_TEST_LOCK_PIN_O), .O_TEST_LOCK_PIN_OE(O_TEST_LOCK_PIN_OE));
